// >>> hdl/fsmr_map.vh
/*
 Register offsets, field values, reset values and timing figures of the
 sensor holding-register bank. Definitions only, no logic.
*/
`ifndef FSMR_MAP_VH
`define FSMR_MAP_VH
`define FSMR_SEQ_HI 16'h0010
`define FSMR_SEQ_LO 16'h0011
`define FSMR_KIN 16'h0012
`define FSMR_DEN 16'h0013
`define FSMR_DYN 16'h0014
`define FSMR_TMP 16'h0016
`define FSMR_STAT 16'h0017
`define FSMR_KINL_HI 16'h0018
`define FSMR_KINL_LO 16'h0019
`define FSMR_KINH 16'h001a
`define FSMR_DYNL_HI 16'h001c
`define FSMR_DYNL_LO 16'h001d
`define FSMR_DYNH 16'h001e
`define FSMR_GUARD 16'h0020
`define FSMR_CMD 16'h0021
`define FSMR_BAUD_HI 16'h0022
`define FSMR_BAUD_LO 16'h0023
`define FSMR_ADDR 16'h0024
`define FSMR_FRAME 16'h0025
`define FSMR_AVG 16'h0026
`define FSMR_A1_SRC 16'h0028
`define FSMR_A1_LO 16'h0029
`define FSMR_A1_HI 16'h002a
`define FSMR_A2_SRC 16'h002c
`define FSMR_A2_LO 16'h002d
`define FSMR_A2_HI 16'h002e
`define FSMR_FN_READ 8'h03
`define FSMR_FN_WR1 8'h06
`define FSMR_FN_WRN 8'h10
`define FSMR_EX_NONE 8'h00
`define FSMR_EX_FUNC 8'h01
`define FSMR_EX_ADDR 8'h02
`define FSMR_EX_VAL 8'h03
`define FSMR_KEY 16'hacdc
`define FSMR_CMD_SAVE 16'h0001
`define FSMR_CMD_RESTART 16'h00ff
`define FSMR_BAUD_A 32'h00002580
`define FSMR_BAUD_B 32'h00004b00
`define FSMR_BAUD_C 32'h0001c200
`define FSMR_FRAME_MAX 16'h0005
`define FSMR_AVG_MIN 16'h0001
`define FSMR_AVG_MAX 16'h0100
`define FSMR_SRC_OFF 16'h0000
`define FSMR_STAT_MASK 16'h0dff
`define FSMR_INVALID 16'hffff
`define FSMR_UA_INVALID 16'h03e8
`define FSMR_UA_LOW 16'h0fa0
`define FSMR_UA_HIGH 16'h4e20
`define FSMR_UA_SPAN 14'h3e80
`define FSMR_DEF_ADDR 16'h0001
`define FSMR_DEF_FRAME 16'h0000
`define FSMR_DEF_AVG 16'h003c
`define FSMR_DEF_A1_SRC 16'h0016
`define FSMR_DEF_A1_LO 16'hf060
`define FSMR_DEF_A1_HI 16'h30d4
`define FSMR_DEF_A2_SRC 16'h0012
`define FSMR_DEF_A2_LO 16'h0000
`define FSMR_DEF_A2_HI 16'h9c40
`define FSMR_CLK_KHZ 100000
`define FSMR_SAVE_MS 1000
`define FSMR_RST_LOW_MS 5000
`define FSMR_RST_HIGH_MS 10000
`define FSMR_SAVE_CYC (`FSMR_SAVE_MS * `FSMR_CLK_KHZ)
`define FSMR_RST_LOW_CYC (`FSMR_RST_LOW_MS * `FSMR_CLK_KHZ)
`define FSMR_RST_HIGH_CYC (`FSMR_RST_HIGH_MS * `FSMR_CLK_KHZ)
`endif

// >>> hdl/fsmr_aout.v
/*
 One 4-20 mA output mapper: turns the selected result into a loop current
 in microamps. Assumes the selected value and its validity are stable
 inputs; a serial divider settles the linear part in about 32 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fsmr_map.vh"
module fsmr_aout (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  input wire ce,
  // selection and mapping points
  input wire [15:0] src,
  input wire [15:0] value,
  input wire valid,
  input wire is_signed,
  input wire [15:0] lo,
  input wire [15:0] hi,
  // loop current in microamps
  output reg [15:0] ua_ff
);
  wire [16:0] x_e = is_signed ? {value[15], value} : {1'b0, value};
  wire [16:0] lo_e = is_signed ? {lo[15], lo} : {1'b0, lo};
  wire [16:0] hi_e = is_signed ? {hi[15], hi} : {1'b0, hi};
  wire below = is_signed ? ($signed(x_e) <= $signed(lo_e)) : (x_e <= lo_e);
  wire above = is_signed ? ($signed(x_e) >= $signed(hi_e)) : (x_e >= hi_e);
  wire [16:0] diff = x_e - lo_e;
  wire [16:0] span = hi_e - lo_e;
  reg busy_ff;
  reg [4:0] cnt_ff;
  reg [30:0] num_ff;
  reg [17:0] rem_ff;
  reg [16:0] den_ff;
  wire [17:0] rem_sh = {rem_ff[16:0], num_ff[30]};
  wire fits = rem_sh >= {1'b0, den_ff};
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ua_ff <= 16'h0000;
      busy_ff <= 1'b0;
      cnt_ff <= 5'h00;
      num_ff <= 31'h00000000;
      rem_ff <= 18'h00000;
      den_ff <= 17'h00000;
    end
    else if (ce)
    begin
      if (busy_ff)
      begin
        rem_ff <= fits ? (rem_sh - {1'b0, den_ff}) : rem_sh;
        num_ff <= {num_ff[29:0], fits};
        cnt_ff <= cnt_ff - 5'h01;
        if (cnt_ff == 5'h00)
        begin
          busy_ff <= 1'b0;
          // quotient stays below the span, so the sum fits
          ua_ff <= `FSMR_UA_LOW + {num_ff[14:0], fits};
        end
      end
      else if (src == `FSMR_SRC_OFF)
        ua_ff <= 16'h0000;
      else if (!valid)
        ua_ff <= `FSMR_UA_INVALID;
      else if (below)
        ua_ff <= `FSMR_UA_LOW;
      else if (above)
        ua_ff <= `FSMR_UA_HIGH;
      else
      begin
        // linear 16 mA span between points
        busy_ff <= 1'b1;
        cnt_ff <= 5'h1e;
        num_ff <= diff * `FSMR_UA_SPAN;
        rem_ff <= 18'h00000;
        den_ff <= span;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/fsmr_restore.v
/*
 Factory-restore pin sequence watcher. Assumes the pin is synchronous to
 the clock and that reset marks power-up; the armed flag is kept for the
 nonvolatile store to load defaults at the next boot.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fsmr_map.vh"
module fsmr_restore #(
  parameter [31:0] LOW_CYC = `FSMR_RST_LOW_CYC,
  parameter [31:0] HIGH_CYC = `FSMR_RST_HIGH_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  input wire ce,
  // pin and result
  input wire restore_pin,
  output reg armed_ff
);
  localparam [2:0] S_LOW = 3'h0, S_READY = 3'h1, S_HIGH = 3'h2;
  localparam [2:0] S_DONE = 3'h3, S_FAIL = 3'h4;
  reg [2:0] st_ff;
  reg [31:0] cnt_ff;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= S_LOW;
      cnt_ff <= 32'h00000000;
      armed_ff <= 1'b0;
    end
    else if (ce)
    begin
      cnt_ff <= cnt_ff + 32'h00000001;
      // low 5 s, high 10 s, low again
      case (st_ff)
        S_LOW:
          if (restore_pin)
            st_ff <= S_FAIL;
          else if (cnt_ff >= LOW_CYC - 32'h00000001)
            st_ff <= S_READY;
        S_READY:
          if (restore_pin)
          begin
            st_ff <= S_HIGH;
            cnt_ff <= 32'h00000001;
          end
        S_HIGH:
          if (!restore_pin)
          begin
            st_ff <= (cnt_ff >= HIGH_CYC) ? S_DONE : S_FAIL;
            armed_ff <= (cnt_ff >= HIGH_CYC);
          end
        S_DONE, S_FAIL:
          cnt_ff <= cnt_ff;
        default:
          st_ff <= S_FAIL;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> hdl/fsmr_regs.v
/*
 Holding-register bank of the fluid sensor: results, status, guarded
 configuration, commands and two analog output mappers. Assumes a Modbus
 RTU frame layer outside that hands over one register word per request.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fsmr_map.vh"
module fsmr_regs #(
  parameter [31:0] SAVE_CYC = `FSMR_SAVE_CYC,
  parameter [31:0] RST_LOW_CYC = `FSMR_RST_LOW_CYC,
  parameter [31:0] RST_HIGH_CYC = `FSMR_RST_HIGH_CYC
) (
  // clock, reset, enable
  input wire core_clk,
  input wire rst_n,
  input wire ce,
  // register request from the frame layer
  input wire req_valid,
  input wire [7:0] req_func,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  // register answer
  output reg rsp_valid_ff,
  output reg [15:0] rsp_rdata_ff,
  output reg [7:0] rsp_exc_ff,
  // measurement results
  input wire meas_strobe,
  input wire [15:0] res_kin,
  input wire [15:0] res_den,
  input wire [15:0] res_dyn,
  input wire [15:0] res_tmp,
  input wire [31:0] res_kinl,
  input wire [15:0] res_kinh,
  input wire [31:0] res_dynl,
  input wire [15:0] res_dynh,
  input wire [7:0] res_invalid,
  input wire [15:0] stat_cond,
  // active serial settings and filter
  output reg [31:0] cfg_baud_ff,
  output reg [15:0] cfg_frame_ff,
  output reg [15:0] cfg_addr_ff,
  output reg [15:0] avg_ff,
  // commands
  output reg save_start_ff,
  output reg save_busy_ff,
  output reg restart_ff,
  // analog outputs in microamps
  output wire [15:0] aout1_ua,
  output wire [15:0] aout2_ua,
  // factory restore
  input wire restore_pin,
  output wire restore_armed
);
  reg [31:0] seq_ff;
  reg [15:0] kin_ff, den_ff, dyn_ff, tmp_ff, kinh_ff, dynh_ff;
  reg [31:0] kinl_ff, dynl_ff;
  reg [7:0] ok_ff;
  reg [15:0] stat_ff;
  reg [15:0] guard_ff, cmd_ff, baud_stage_ff;
  reg [31:0] baud_ff;
  reg [15:0] frame_ff, addr_ff;
  reg [15:0] a1_src_ff, a1_lo_ff, a1_hi_ff, a2_src_ff, a2_lo_ff, a2_hi_ff;
  reg [31:0] save_cnt_ff;
  reg [15:0] rd_data;
  reg rd_ok, wr_cfg, val_ok;
  reg [7:0] nxt_exc;
  wire is_rd = req_func == `FSMR_FN_READ;
  wire is_wr = (req_func == `FSMR_FN_WR1) | (req_func == `FSMR_FN_WRN);
  wire is_guard = req_addr == `FSMR_GUARD;
  wire unlocked = guard_ff == `FSMR_KEY;
  wire [31:0] baud_new = {baud_stage_ff, req_wdata};
  wire [16:0] a1_sel, a2_sel;

  // source codes mapped to stored results
  function [16:0] pick;
    input [15:0] src;
    begin
      case (src)
        16'h0012: pick = {ok_ff[0], kin_ff};
        16'h0013: pick = {ok_ff[1], den_ff};
        16'h0014: pick = {ok_ff[2], dyn_ff};
        16'h0016: pick = {ok_ff[3], tmp_ff};
        16'h001a: pick = {ok_ff[5], kinh_ff};
        16'h001e: pick = {ok_ff[7], dynh_ff};
        default: pick = {1'b0, `FSMR_INVALID};
      endcase
    end
  endfunction

  function src_legal;
    input [15:0] src;
    begin
      src_legal = (src == 16'h0000) | (src == 16'h0012) | (src == 16'h0013) |
        (src == 16'h0014) | (src == 16'h0016) | (src == 16'h001a) | (src == 16'h001e);
    end
  endfunction

  assign a1_sel = pick(a1_src_ff);
  assign a2_sel = pick(a2_src_ff);

  // read mux; high word at the lower address
  always @*
  begin
    rd_data = 16'h0000;
    rd_ok = 1'b1;
    case (req_addr)
      `FSMR_SEQ_HI: rd_data = seq_ff[31:16];
      `FSMR_SEQ_LO: rd_data = seq_ff[15:0];
      `FSMR_KIN: rd_data = kin_ff;
      `FSMR_DEN: rd_data = den_ff;
      `FSMR_DYN: rd_data = dyn_ff;
      `FSMR_TMP: rd_data = tmp_ff;
      `FSMR_STAT: rd_data = stat_ff;
      `FSMR_KINL_HI: rd_data = kinl_ff[31:16];
      `FSMR_KINL_LO: rd_data = kinl_ff[15:0];
      `FSMR_KINH: rd_data = kinh_ff;
      `FSMR_DYNL_HI: rd_data = dynl_ff[31:16];
      `FSMR_DYNL_LO: rd_data = dynl_ff[15:0];
      `FSMR_DYNH: rd_data = dynh_ff;
      `FSMR_GUARD: rd_data = guard_ff;
      `FSMR_CMD: rd_data = cmd_ff;
      `FSMR_BAUD_HI: rd_data = baud_ff[31:16];
      `FSMR_BAUD_LO: rd_data = baud_ff[15:0];
      `FSMR_ADDR: rd_data = addr_ff;
      `FSMR_FRAME: rd_data = frame_ff;
      `FSMR_AVG: rd_data = avg_ff;
      `FSMR_A1_SRC: rd_data = a1_src_ff;
      `FSMR_A1_LO: rd_data = a1_lo_ff;
      `FSMR_A1_HI: rd_data = a1_hi_ff;
      `FSMR_A2_SRC: rd_data = a2_src_ff;
      `FSMR_A2_LO: rd_data = a2_lo_ff;
      `FSMR_A2_HI: rd_data = a2_hi_ff;
      default: rd_ok = 1'b0;
    endcase
  end

  // write decode and value checks
  always @*
  begin
    wr_cfg = (req_addr >= `FSMR_CMD) && (req_addr <= `FSMR_A2_HI) &&
      (req_addr != 16'h0027) && (req_addr != 16'h002b);
    val_ok = 1'b1;
    case (req_addr)
      `FSMR_BAUD_LO: val_ok = (baud_new == `FSMR_BAUD_A) |
        (baud_new == `FSMR_BAUD_B) | (baud_new == `FSMR_BAUD_C);
      `FSMR_FRAME: val_ok = req_wdata <= `FSMR_FRAME_MAX;
      `FSMR_AVG: val_ok = (req_wdata >= `FSMR_AVG_MIN) && (req_wdata <= `FSMR_AVG_MAX);
      `FSMR_A1_SRC, `FSMR_A2_SRC: val_ok = src_legal(req_wdata);
      default: val_ok = 1'b1;
    endcase
    // only read, single write and multiple write
    if (!is_rd && !is_wr)
      nxt_exc = `FSMR_EX_FUNC;
    else if (is_rd)
      nxt_exc = rd_ok ? `FSMR_EX_NONE : `FSMR_EX_ADDR;
    else if (!is_guard && !wr_cfg)
      nxt_exc = `FSMR_EX_ADDR;
    // rejected values leave the setting alone
    else if (wr_cfg && unlocked && !val_ok)
      nxt_exc = `FSMR_EX_VAL;
    else
      nxt_exc = `FSMR_EX_NONE;
  end

  // locked writes are acknowledged but dropped
  wire do_wr = req_valid && is_wr && (nxt_exc == `FSMR_EX_NONE) && (is_guard || unlocked);

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= 16'h0000;
      rsp_exc_ff <= `FSMR_EX_NONE;
      seq_ff <= 32'h00000000;
      kin_ff <= `FSMR_INVALID;
      den_ff <= `FSMR_INVALID;
      dyn_ff <= `FSMR_INVALID;
      tmp_ff <= `FSMR_INVALID;
      kinh_ff <= `FSMR_INVALID;
      dynh_ff <= `FSMR_INVALID;
      kinl_ff <= {`FSMR_INVALID, `FSMR_INVALID};
      dynl_ff <= {`FSMR_INVALID, `FSMR_INVALID};
      ok_ff <= 8'h00;
      stat_ff <= 16'h0000;
      guard_ff <= 16'h0000;
      cmd_ff <= 16'h0000;
      baud_stage_ff <= 16'h0000;
      baud_ff <= `FSMR_BAUD_B;
      cfg_baud_ff <= `FSMR_BAUD_B;
      frame_ff <= `FSMR_DEF_FRAME;
      cfg_frame_ff <= `FSMR_DEF_FRAME;
      addr_ff <= `FSMR_DEF_ADDR;
      cfg_addr_ff <= `FSMR_DEF_ADDR;
      avg_ff <= `FSMR_DEF_AVG;
      a1_src_ff <= `FSMR_DEF_A1_SRC;
      a1_lo_ff <= `FSMR_DEF_A1_LO;
      a1_hi_ff <= `FSMR_DEF_A1_HI;
      a2_src_ff <= `FSMR_DEF_A2_SRC;
      a2_lo_ff <= `FSMR_DEF_A2_LO;
      a2_hi_ff <= `FSMR_DEF_A2_HI;
      save_start_ff <= 1'b0;
      save_busy_ff <= 1'b0;
      save_cnt_ff <= 32'h00000000;
      restart_ff <= 1'b0;
    end
    else if (ce)
    begin
      rsp_valid_ff <= 1'b0;
      save_start_ff <= 1'b0;
      restart_ff <= 1'b0;
      // live fault flags; reserved bits read zero
      stat_ff <= stat_cond & `FSMR_STAT_MASK;
      if (save_cnt_ff != 32'h00000000)
        save_cnt_ff <= save_cnt_ff - 32'h00000001;
      else
        save_busy_ff <= 1'b0;
      if (meas_strobe)
      begin
        seq_ff <= seq_ff + 32'h00000001;
        // invalid results read as all ones
        kin_ff <= res_invalid[0] ? `FSMR_INVALID : res_kin;
        den_ff <= res_invalid[1] ? `FSMR_INVALID : res_den;
        dyn_ff <= res_invalid[2] ? `FSMR_INVALID : res_dyn;
        tmp_ff <= res_invalid[3] ? `FSMR_INVALID : res_tmp;
        kinl_ff <= res_invalid[4] ? {`FSMR_INVALID, `FSMR_INVALID} : res_kinl;
        kinh_ff <= res_invalid[5] ? `FSMR_INVALID : res_kinh;
        dynl_ff <= res_invalid[6] ? {`FSMR_INVALID, `FSMR_INVALID} : res_dynl;
        dynh_ff <= res_invalid[7] ? `FSMR_INVALID : res_dynh;
        ok_ff <= ~res_invalid;
      end
      if (req_valid)
      begin
        rsp_valid_ff <= 1'b1;
        rsp_exc_ff <= nxt_exc;
        rsp_rdata_ff <= (is_rd && rd_ok) ? rd_data : 16'h0000;
      end
      if (do_wr)
      begin
        case (req_addr)
          // guard always writable, key opens block
          `FSMR_GUARD: guard_ff <= req_wdata;
          `FSMR_CMD:
          begin
            cmd_ff <= req_wdata;
            // save runs for about one second
            if (req_wdata == `FSMR_CMD_SAVE)
            begin
              save_start_ff <= 1'b1;
              save_busy_ff <= 1'b1;
              save_cnt_ff <= SAVE_CYC - 32'h00000001;
            end
            // restart; serial settings go live here
            if (req_wdata == `FSMR_CMD_RESTART)
            begin
              restart_ff <= 1'b1;
              cfg_baud_ff <= baud_ff;
              cfg_frame_ff <= frame_ff;
              cfg_addr_ff <= addr_ff;
              guard_ff <= 16'h0000;
            end
          end
          // high word waits for the low word to be checked as a whole
          `FSMR_BAUD_HI: baud_stage_ff <= req_wdata;
          `FSMR_BAUD_LO: baud_ff <= baud_new;
          `FSMR_ADDR: addr_ff <= req_wdata;
          `FSMR_FRAME: frame_ff <= req_wdata;
          `FSMR_AVG: avg_ff <= req_wdata;
          `FSMR_A1_SRC: a1_src_ff <= req_wdata;
          `FSMR_A1_LO: a1_lo_ff <= req_wdata;
          `FSMR_A1_HI: a1_hi_ff <= req_wdata;
          `FSMR_A2_SRC: a2_src_ff <= req_wdata;
          `FSMR_A2_LO: a2_lo_ff <= req_wdata;
          `FSMR_A2_HI: a2_hi_ff <= req_wdata;
          default: cmd_ff <= cmd_ff;
        endcase
      end
    end
  end

  fsmr_aout u_aout1 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .src(a1_src_ff),
    .value(a1_sel[15:0]),
    .valid(a1_sel[16]),
    .is_signed(a1_src_ff == `FSMR_DEF_A1_SRC),
    .lo(a1_lo_ff),
    .hi(a1_hi_ff),
    .ua_ff(aout1_ua)
  );

  // temperature is the only signed source
  fsmr_aout u_aout2 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .src(a2_src_ff),
    .value(a2_sel[15:0]),
    .valid(a2_sel[16]),
    .is_signed(a2_src_ff == `FSMR_DEF_A1_SRC),
    .lo(a2_lo_ff),
    .hi(a2_hi_ff),
    .ua_ff(aout2_ua)
  );

  fsmr_restore #(
    .LOW_CYC(RST_LOW_CYC),
    .HIGH_CYC(RST_HIGH_CYC)
  ) u_restore (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .restore_pin(restore_pin),
    .armed_ff(restore_armed)
  );
endmodule
`default_nettype wire

// >>> sim/fsmr_master.sv
/*
 Frame-layer master model: issues one register word request and collects
 the answer. Assumes the bank answers one enabled cycle after the request.
*/
`timescale 1ns/100ps
`default_nettype none
module fsmr_master (
  // clock
  input wire logic core_clk,
  // request
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  // answer
  input wire logic rsp_valid_ff,
  input wire logic [15:0] rsp_rdata_ff,
  input wire logic [7:0] rsp_exc_ff
);
  initial
  begin
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end
  // callers send the key and the zero through this task
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
    output logic [15:0] q, output logic [7:0] x, output logic late);
    int n;
    begin
      @(posedge core_clk);
      #1;
      req_valid = 1'b1;
      req_func = f;
      req_addr = a;
      req_wdata = d;
      @(posedge core_clk);
      #1;
      req_valid = 1'b0;
      // released lines must not keep the last value
      req_addr = ~a;
      req_wdata = ~d;
      n = 0;
      while (rsp_valid_ff !== 1'b1 && n < 8)
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
      q = rsp_rdata_ff;
      x = rsp_exc_ff;
      late = (n == 8);
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/fsmr_regs_sva.sv
/*
 Port checker of the register bank. Assumes one clock domain and the bind
 at the foot of this file.
*/
`timescale 1ns/100ps
`default_nettype none
module fsmr_regs_sva #(
  parameter [31:0] SAVE_CYC = 32'd20
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic rsp_valid_ff,
  input wire logic [7:0] rsp_exc_ff,
  // settings and commands
  input wire logic [31:0] cfg_baud_ff,
  input wire logic [15:0] cfg_frame_ff,
  input wire logic [15:0] cfg_addr_ff,
  input wire logic [15:0] avg_ff,
  input wire logic save_start_ff,
  input wire logic save_busy_ff,
  input wire logic restart_ff,
  // outputs
  input wire logic [15:0] aout1_ua,
  input wire logic [15:0] aout2_ua,
  input wire logic restore_armed
);
  logic [31:0] busy_cnt_ff;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_cnt_ff <= 32'h0;
    else if (ce)
      busy_cnt_ff <= save_busy_ff ? busy_cnt_ff + 32'h1 : 32'h0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_rsp_next_cycle: assert property (req_valid && ce |=> rsp_valid_ff)
    else $error("answer missing after request");
  a_rsp_has_cause: assert property (rsp_valid_ff |-> $past(req_valid))
    else $error("answer without request");
  a_bad_func_exc: assert property (req_valid && ce && !(req_func inside {8'h03, 8'h06,
    8'h10}) |=> rsp_exc_ff == 8'h01)
    else $error("unknown function not refused");
  a_save_busy_len: assert property ($fell(save_busy_ff) |-> busy_cnt_ff == SAVE_CYC)
    else $error("save busy length wrong");
  a_save_starts_busy: assert property (save_start_ff |=> save_busy_ff && !save_start_ff)
    else $error("save start not followed by busy");
  a_restart_pulse: assert property (restart_ff |=> !restart_ff)
    else $error("restart not a pulse");
  a_serial_on_restart: assert property ($changed({cfg_baud_ff, cfg_frame_ff, cfg_addr_ff})
    |-> restart_ff || $past(restart_ff))
    else $error("serial setting changed without restart");
  a_baud_frame_legal: assert property (cfg_baud_ff inside {32'h2580, 32'h4b00, 32'h1c200}
    && cfg_frame_ff <= 16'h0005)
    else $error("illegal serial setting");
  a_avg_in_range: assert property (avg_ff >= 16'h0001 && avg_ff <= 16'h0100)
    else $error("averaging length out of range");
  a_aout_levels: assert property ((aout1_ua inside {16'h0, 16'h03e8, [16'h0fa0:16'h4e20]})
    && (aout2_ua inside {16'h0, 16'h03e8, [16'h0fa0:16'h4e20]}))
    else $error("loop current outside legal levels");
  a_armed_sticky: assert property (restore_armed |=> restore_armed)
    else $error("restore flag dropped");
endmodule
bind fsmr_regs fsmr_regs_sva #(.SAVE_CYC(SAVE_CYC)) fsmr_regs_sva_i (.core_clk(core_clk),
  .rst_n(rst_n), .ce(ce), .req_valid(req_valid), .req_func(req_func),
  .rsp_valid_ff(rsp_valid_ff), .rsp_exc_ff(rsp_exc_ff), .cfg_baud_ff(cfg_baud_ff),
  .cfg_frame_ff(cfg_frame_ff), .cfg_addr_ff(cfg_addr_ff), .avg_ff(avg_ff),
  .save_start_ff(save_start_ff), .save_busy_ff(save_busy_ff), .restart_ff(restart_ff),
  .aout1_ua(aout1_ua), .aout2_ua(aout2_ua), .restore_armed(restore_armed));
`default_nettype wire

// >>> sim/fsmr_regs_tb.sv
/*
 Self-checking bench of the register bank. Assumes the master model in
 front and short save and restore counts.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fsmr_map.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module fsmr_regs_tb;
  logic core_clk, rst_n, ce, req_valid, rsp_valid_ff, meas_strobe, save_start_ff;
  logic save_busy_ff, restart_ff, restore_pin, restore_armed;
  logic [7:0] req_func, rsp_exc_ff, res_invalid;
  logic [15:0] req_addr, req_wdata, rsp_rdata_ff, res_kin, res_den, res_dyn, res_tmp;
  logic [15:0] res_kinh, res_dynh, stat_cond, cfg_frame_ff, cfg_addr_ff, avg_ff;
  logic [15:0] aout1_ua, aout2_ua;
  logic [31:0] res_kinl, res_dynl, cfg_baud_ff;
  int n_errors = 0;
  int check_count = 0;
  logic [15:0] ra[14] = '{16'h20, 16'h22, 16'h23, 16'h24, 16'h25, 16'h26, 16'h28,
    16'h29, 16'h2a, 16'h2c, 16'h2d, 16'h2e, 16'h11, 16'h12};
  logic [15:0] rv[14] = '{16'h0, 16'h0, 16'h4b00, 16'h1, 16'h0, 16'h3c, 16'h16,
    16'hf060, 16'h30d4, 16'h12, 16'h0, 16'h9c40, 16'h0, 16'hffff};
  logic [15:0] tv[3] = '{16'h8000, 16'h7000, 16'h0000};
  logic [15:0] ta[3] = '{16'h0fa0, 16'h4e20, 16'h1ec6};
  logic [15:0] sc[7] = '{16'h12, 16'h13, 16'h14, 16'h16, 16'h1a, 16'h1e, 16'h0};
  fsmr_regs #(.SAVE_CYC(32'd20), .RST_LOW_CYC(32'd30), .RST_HIGH_CYC(32'd50)) fsmr_regs_i (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
    .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid_ff(rsp_valid_ff), .rsp_rdata_ff(rsp_rdata_ff), .rsp_exc_ff(rsp_exc_ff),
    .meas_strobe(meas_strobe), .res_kin(res_kin), .res_den(res_den), .res_dyn(res_dyn),
    .res_tmp(res_tmp), .res_kinl(res_kinl), .res_kinh(res_kinh), .res_dynl(res_dynl),
    .res_dynh(res_dynh), .res_invalid(res_invalid), .stat_cond(stat_cond),
    .cfg_baud_ff(cfg_baud_ff), .cfg_frame_ff(cfg_frame_ff), .cfg_addr_ff(cfg_addr_ff),
    .avg_ff(avg_ff), .save_start_ff(save_start_ff), .save_busy_ff(save_busy_ff),
    .restart_ff(restart_ff), .aout1_ua(aout1_ua), .aout2_ua(aout2_ua),
    .restore_pin(restore_pin), .restore_armed(restore_armed));
  fsmr_master fsmr_master_i (.core_clk(core_clk), .req_valid(req_valid),
    .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid_ff(rsp_valid_ff), .rsp_rdata_ff(rsp_rdata_ff), .rsp_exc_ff(rsp_exc_ff));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic summarize();
    begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task automatic op(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
    input logic [15:0] eq, input logic [7:0] ex);
    logic [15:0] q;
    logic [7:0] x;
    logic late;
    begin
      fsmr_master_i.xfer(f, a, d, q, x, late);
      if (late)
      begin
        n_errors++;
        summarize();
      end
      else
        `CHK({q, x}, {eq, ex})
    end
  endtask
  task automatic strobe(input logic [15:0] t);
    begin
      res_tmp = t;
      meas_strobe = 1'b1;
      @(posedge core_clk);
      #1;
      meas_strobe = 1'b0;
      repeat (40) @(posedge core_clk);
      #1;
    end
  endtask
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    meas_strobe = 1'b0;
    {res_kin, res_den, res_dyn, res_tmp, res_kinh, res_dynh} = '0;
    {res_kinl, res_dynl} = '0;
    res_invalid = 8'hff;
    stat_cond = 16'h0;
    restore_pin = 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 14; i++)
      op(8'h03, ra[i], 16'h0, rv[i], 8'h00);
    `CHK(cfg_baud_ff, 32'h4b00)
    op(8'h04, 16'h20, 16'h0, 16'h0, 8'h01);
    op(8'h03, 16'h27, 16'h0, 16'h0, 8'h02);
    op(8'h06, 16'h12, 16'h5, 16'h0, 8'h02);
    op(8'h06, 16'h26, 16'ha, 16'h0, 8'h00);
    op(8'h03, 16'h26, 16'h0, 16'h3c, 8'h00);
    op(8'h06, 16'h20, 16'hacdc, 16'h0, 8'h00);
    op(8'h06, 16'h26, 16'h0, 16'h0, 8'h03);
    op(8'h10, 16'h26, 16'h101, 16'h0, 8'h03);
    op(8'h10, 16'h26, 16'h100, 16'h0, 8'h00);
    `CHK(avg_ff, 16'h0100)
    op(8'h06, 16'h25, 16'h6, 16'h0, 8'h03);
    op(8'h06, 16'h25, 16'h5, 16'h0, 8'h00);
    op(8'h06, 16'h22, 16'h1, 16'h0, 8'h00);
    op(8'h06, 16'h23, 16'hc200, 16'h0, 8'h00);
    op(8'h03, 16'h22, 16'h0, 16'h1, 8'h00);
    op(8'h06, 16'h23, 16'h1234, 16'h0, 8'h03);
    op(8'h06, 16'h24, 16'h7, 16'h0, 8'h00);
    `CHK({cfg_baud_ff, cfg_frame_ff, cfg_addr_ff}, {32'h4b00, 16'h0, 16'h1})
    res_kin = 16'h2710;
    res_den = 16'h1234;
    res_kinl = 32'h00050006;
    res_invalid = 8'h00;
    stat_cond = 16'hffff;
    strobe(16'h8000);
    strobe(tv[0]);
    op(8'h03, 16'h10, 16'h0, 16'h0, 8'h00);
    op(8'h03, 16'h11, 16'h0, 16'h2, 8'h00);
    op(8'h03, 16'h13, 16'h0, 16'h1234, 8'h00);
    op(8'h03, 16'h18, 16'h0, 16'h5, 8'h00);
    op(8'h03, 16'h17, 16'h0, 16'h0dff, 8'h00);
    `CHK(aout2_ua, 16'h1f40)
    for (int i = 0; i < 3; i++)
    begin
      strobe(tv[i]);
      `CHK(aout1_ua, ta[i])
    end
    res_invalid = 8'h08;
    strobe(16'h0);
    `CHK(aout1_ua, 16'h03e8)
    op(8'h03, 16'h16, 16'h0, 16'hffff, 8'h00);
    // temperature points written signed like the result
    op(8'h06, 16'h29, 16'hfc18, 16'h0, 8'h00);
    op(8'h06, 16'h2c, 16'h11, 16'h0, 8'h03);
    for (int i = 0; i < 7; i++)
      op(8'h06, 16'h2c, sc[i], 16'h0, 8'h00);
    // a running division holds the old current for up to 32 cycles
    repeat (40) @(posedge core_clk);
    #1;
    `CHK(aout2_ua, 16'h0)
    op(8'h06, 16'h21, 16'h1, 16'h0, 8'h00);
    `CHK(save_busy_ff, 1'b1)
    repeat (25) @(posedge core_clk);
    `CHK(save_busy_ff, 1'b0)
    op(8'h06, 16'h21, 16'hff, 16'h0, 8'h00);
    `CHK({cfg_baud_ff, cfg_frame_ff, cfg_addr_ff}, {32'h1c200, 16'h5, 16'h7})
    op(8'h06, 16'h20, 16'h0, 16'h0, 8'h00);
    op(8'h06, 16'h26, 16'h5, 16'h0, 8'h00);
    op(8'h03, 16'h26, 16'h0, 16'h100, 8'h00);
    // pin high well past the hold, then back low
    restore_pin = 1'b1;
    repeat (60) @(posedge core_clk);
    #1;
    restore_pin = 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK(restore_armed, 1'b1)
    summarize();
  end
endmodule
`default_nettype wire
